// *** mux_bus_handshake_port.v ***
/*
  Eight-bit port: multiplexed low-address/data bus in expanded mode,
  general-purpose and handshake port in single-chip mode, with register port.
  Assumes all inputs are synchronous to clock; ePhase marks E high time;
  phaseTwoFall is a one-cycle pulse at the falling edge of the phase-two clock.
*/
// How it works
// - Expanded mode drives low address first half, data second half of cycle.
// - Bus output buffer on when tristate control low, pins float when high.
// - Address enable routes address, write-data enable routes write data.
// - Read data captured during E high, passed to CPU under read enable.
// - Low-power signal low disables input buffers; high enables them.
// - Four cycle types; internal read data driven only when visible.
// - Direction register written and read back; reset clears all bits.
// - Open-drain control floats ones, still drives zeros, all bits together.
// - Open-drain permitted only in single-chip mode.
// - Output handshake drives direction-zero bits only while strobe active.
// - Edge-select bit decides which strobe level is active.
// - Data read returns output node if full-output handshake or output, else pin.
// - Writes to data or latched address load the same output latch.
// - Selected strobe edge captures pins into latched register.
// - Strobe edge in wait mode still interrupts; no data captured.
// - Handshake and out-direction both set selects full-output handshake.
// - Register writes take effect at phase-two falling edge, except the flag clear, which acts at once.
// - Synchronized strobe edge sets flag and clears auto-clear arming.
`timescale 1ns/1ns
`include "mux_bus_port_defs.vh"
module mux_bus_handshake_port #(
    parameter WIDTH = 8
) (
    input wire clock,
    input wire srst,
    input wire expandedModeSel,
    input wire ePhase,
    input wire phaseTwoFall,
    input wire busTristateCtl,
    input wire addrOutEn,
    input wire wrDataOutEn,
    input wire rdDataInEn,
    input wire internalReadCycle,
    input wire lowpowerN,
    input wire [WIDTH-1:0] busAddr,
    input wire [WIDTH-1:0] busWrData,
    input wire [WIDTH-1:0] internalRdData,
    input wire strobeAIn,
    input wire [WIDTH-1:0] pinIn,
    input wire [3:0] regAddr,
    input wire [WIDTH-1:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [WIDTH-1:0] pinOut,
    output reg [WIDTH-1:0] pinOeN,
    output reg [WIDTH-1:0] cpuRdData,
    output reg [WIDTH-1:0] regRdData,
    output reg strobeAFlag,
    output reg irq
);

////////////////////////////////////////////////////////////////////////////////
// Registers and write staging
reg [WIDTH-1:0] dirReg;
reg [WIDTH-1:0] outLatch;
reg [WIDTH-1:0] latchedDataReg;
reg [WIDTH-1:0] readHold;
reg [4:0] ctrl;
reg irqEnable;
reg autoClearArmed;
reg pendWr;
reg [3:0] pendAddr;
reg [WIDTH-1:0] pendData;
reg strobePrev;
reg edgeSeen;

wire openDrainSel = ctrl[`CTRL_OPEN_DRAIN];
wire handshakeEn = ctrl[`CTRL_HANDSHAKE];
wire outDirSel = ctrl[`CTRL_OUT_DIR];
wire strobeAEdgeSel = ctrl[`CTRL_EDGE_SEL];
wire internalReadVisible = ctrl[`CTRL_IRV];

wire fullOutHs = handshakeEn & outDirSel;
wire strobeActive = strobeAIn == strobeAEdgeSel;
// Edge of the selected polarity: rising when edge-select is one
wire strobeAEdgePulse = strobeActive & (strobePrev != strobeAIn);
wire [WIDTH-1:0] inBuf = lowpowerN ? pinIn : {WIDTH{1'b0}};

////////////////////////////////////////////////////////////////////////////////
// Single-chip pin drive
// Per-bit single-chip drive and port read
wire [WIDTH-1:0] scOut;
wire [WIDTH-1:0] scOeN;
wire [WIDTH-1:0] portRead;
genvar b;
generate
    for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
        // Output handshake overrides a clear direction bit while strobe active
        wire drives = dirReg[b] | (fullOutHs & strobeActive);
        // Open-drain: a one releases the pin instead of pulling up
        wire floatOne = openDrainSel & outLatch[b];
        // Output node read back whenever the port side owns the bit
        wire readsNode = fullOutHs | dirReg[b];
        assign scOut[b] = drives & outLatch[b];
        assign scOeN[b] = drives ? floatOne : 1'b1;
        assign portRead[b] = readsNode ? outLatch[b] : inBuf[b];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Expanded bus source, one-hot
localparam SRC_NONE = 4'b0001;
localparam SRC_ADDR = 4'b0010;
localparam SRC_WDATA = 4'b0100;
localparam SRC_IREAD = 4'b1000;
reg [3:0] busSrc;
always @* begin
    busSrc = SRC_NONE;
    // Address wins over data if both enables overlap
    if (!busTristateCtl) begin
        if (addrOutEn) begin
            busSrc = SRC_ADDR;
        end else if (wrDataOutEn) begin
            busSrc = SRC_WDATA;
        end else if (internalReadCycle && internalReadVisible) begin
            // Hidden by default so it cannot fight an external device
            busSrc = SRC_IREAD;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin drive select
reg [WIDTH-1:0] next_oeN;
reg [WIDTH-1:0] next_out;
always @* begin
    next_oeN = {WIDTH{1'b1}};
    next_out = {WIDTH{1'b0}};
    if (expandedModeSel) begin
        // Wired-OR and handshake are meaningless on the shared bus
        case (busSrc)
            SRC_ADDR: begin
                next_out = busAddr;
                next_oeN = {WIDTH{1'b0}};
            end
            SRC_WDATA: begin
                next_out = busWrData;
                next_oeN = {WIDTH{1'b0}};
            end
            SRC_IREAD: begin
                next_out = internalRdData;
                next_oeN = {WIDTH{1'b0}};
            end
            default: begin
                next_out = {WIDTH{1'b0}};
                next_oeN = {WIDTH{1'b1}};
            end
        endcase
    end else begin
        next_out = scOut;
        next_oeN = scOeN;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register read mux
reg [WIDTH-1:0] next_rd;
always @* begin
    next_rd = {WIDTH{1'b0}};
    case (regAddr)
        `ADDR_PORT_DATA: begin
            next_rd = portRead;
        end
        `ADDR_LATCHED_DATA: begin
            next_rd = latchedDataReg;
        end
        `ADDR_DIR: begin
            next_rd = dirReg;
        end
        `ADDR_CTRL: begin
            next_rd = {{(WIDTH-5){1'b0}}, ctrl};
        end
        `ADDR_IRQ_STATUS: begin
            next_rd = {{(WIDTH-1){1'b0}}, strobeAFlag};
        end
        `ADDR_IRQ_ENABLE: begin
            next_rd = {{(WIDTH-1){1'b0}}, irqEnable};
        end
        default: begin
            next_rd = {WIDTH{1'b0}};
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Decoded strobes
wire commitWr = phaseTwoFall & pendWr;
// Write-one-to-clear; a zero written leaves the flag alone
wire clearWr = regWr & (regAddr == `ADDR_IRQ_CLEAR) & regWrData[0];
wire statusRd = regRd & (regAddr == `ADDR_IRQ_STATUS);
wire latchedAccess = (regRd | regWr) & (regAddr == `ADDR_LATCHED_DATA);
wire autoClear = autoClearArmed & latchedAccess;
// Strobe edges are ignored on the shared bus
wire edgeTake = strobeAEdgePulse & ~expandedModeSel;

////////////////////////////////////////////////////////////////////////////////
// Pin outputs
always @(posedge clock) begin
    // Pins float through reset so nothing fights an attached device
    if (srst) begin
        pinOut <= {WIDTH{1'b0}};
        pinOeN <= {WIDTH{1'b1}};
    end else begin
        pinOut <= next_out;
        pinOeN <= next_oeN;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read data stand one cycle after the read strobe only
always @(posedge clock) begin
    if (srst) begin
        regRdData <= {WIDTH{1'b0}};
    end else begin
        regRdData <= regRd ? next_rd : {WIDTH{1'b0}};
    end
end

////////////////////////////////////////////////////////////////////////////////
// Expanded read path
always @(posedge clock) begin
    if (srst) begin
        readHold <= {WIDTH{1'b0}};
        cpuRdData <= {WIDTH{1'b0}};
    end else begin
        if (ePhase && lowpowerN) begin
            readHold <= pinIn;
        end
        // Held value gives the CPU stable data after E falls
        if (rdDataInEn) begin
            cpuRdData <= readHold;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Write staging; a second write before the phase-two fall replaces the first
always @(posedge clock) begin
    if (srst) begin
        pendWr <= 1'b0;
        pendAddr <= 4'h0;
        pendData <= {WIDTH{1'b0}};
    end else if (regWr) begin
        pendWr <= 1'b1;
        pendAddr <= regAddr;
        pendData <= regWrData;
    end else if (phaseTwoFall) begin
        pendWr <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register commit; software needs a phase-two fall between writes
always @(posedge clock) begin
    if (srst) begin
        dirReg <= `RST_DIR;
        ctrl <= `RST_CTRL;
        outLatch <= {WIDTH{1'b0}};
        irqEnable <= 1'b0;
    end else if (commitWr) begin
        case (pendAddr)
            `ADDR_PORT_DATA: begin
                outLatch <= pendData;
            end
            `ADDR_LATCHED_DATA: begin
                outLatch <= pendData;
            end
            `ADDR_DIR: begin
                dirReg <= pendData;
            end
            `ADDR_CTRL: begin
                ctrl <= pendData[4:0];
            end
            `ADDR_IRQ_ENABLE: begin
                irqEnable <= pendData[0];
            end
            default: ;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Strobe edge capture
always @(posedge clock) begin
    if (srst) begin
        // Starts low, the idle level of the strobe pin
        strobePrev <= 1'b0;
        latchedDataReg <= {WIDTH{1'b0}};
        edgeSeen <= 1'b0;
    end else begin
        strobePrev <= strobeAIn;
        // Buffers off in low power: the edge still counts, the data does not
        if (edgeTake && lowpowerN) begin
            latchedDataReg <= pinIn;
        end
        if (edgeTake) begin
            edgeSeen <= 1'b1;
        end else if (phaseTwoFall) begin
            edgeSeen <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Flag and auto-clear arming; a set in the same cycle as a clear wins
always @(posedge clock) begin
    if (srst) begin
        strobeAFlag <= 1'b0;
        autoClearArmed <= 1'b0;
    end else if (edgeSeen && phaseTwoFall) begin
        strobeAFlag <= 1'b1;
        autoClearArmed <= 1'b0;
    end else if (clearWr || autoClear) begin
        strobeAFlag <= 1'b0;
        autoClearArmed <= 1'b0;
    end else if (statusRd && strobeAFlag) begin
        // Arm on a status read that sees the flag set
        autoClearArmed <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Level interrupt, one cycle behind the flag
always @(posedge clock) begin
    if (srst) begin
        irq <= 1'b0;
    end else begin
        irq <= strobeAFlag & irqEnable;
    end
end

endmodule

// *** mux_bus_handshake_port_tb_top.sv ***
/* Testbench: register tasks, expanded bus, handshake and flag.
   Assumes the pin partner and the bound checker. */
`timescale 1ns/1ns
module mux_bus_handshake_port_tb_top;
    logic clock = 1'b0, srst = 1'b1, ePhase = 1'b0, phaseTwoFall = 1'b0, devDrive = 1'b0;
    logic expandedModeSel = 1'b0, busTristateCtl = 1'b1, addrOutEn = 1'b0, wrDataOutEn = 1'b0;
    logic rdDataInEn = 1'b0, lowpowerN = 1'b1, strobeAIn = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic internalReadCycle = 1'b0;
    logic [7:0] internalRdData = 8'h00;
    logic [7:0] busAddr = 8'h00, busWrData = 8'h00, regWrData = 8'h00, devData = 8'h00;
    logic [7:0] pinIn, pinOut, pinOeN, cpuRdData, regRdData;
    logic strobeAFlag, irq;
    logic [1:0] ph = 2'h0;
    int compares = 0, miscompares = 0;
    mux_bus_handshake_port i_mux_bus_handshake_port (.clock, .srst, .expandedModeSel, .ePhase,
        .phaseTwoFall, .busTristateCtl, .addrOutEn, .wrDataOutEn, .rdDataInEn,
        .internalReadCycle, .lowpowerN, .busAddr, .busWrData, .internalRdData,
        .strobeAIn, .pinIn, .regAddr, .regWrData, .regWr, .regRd, .pinOut, .pinOeN,
        .cpuRdData, .regRdData, .strobeAFlag, .irq);
    port_pin_partner i_port_pin_partner (.pinOut, .pinOeN, .devData, .devDrive, .pinIn);
    initial forever #10 clock = ~clock;
    // E phase of four clocks; writes commit mid E high
    always @(posedge clock) begin
        ph <= ph + 2'h1;
        ePhase <= ph[1];
        phaseTwoFall <= ph == 2'h2;
    end
    //////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Six idle cycles so every write meets a phase-two fall alone
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        cyc(1);
        regWr <= 1'b0;
        cyc(6);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        regAddr <= a;
        regRd <= 1'b1;
        cyc(1);
        regRd <= 1'b0;
        chk(regRdData, e);
        cyc(1);
    endtask
    task automatic conclude;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        cyc(10);
        srst <= 1'b0;
        cyc(1);
        rd(4'h2, 8'h00);
        wr(4'h2, 8'hff);
        rd(4'h2, 8'hff);
        wr(4'h0, 8'h5a);
        chk(pinOut, 8'h5a);
        wr(4'h1, 8'h3c);
        chk(pinOut, 8'h3c);
        wr(4'h3, 8'h01);
        chk(pinOeN, 8'h3c);
        expandedModeSel <= 1'b1;
        busTristateCtl <= 1'b0;
        addrOutEn <= 1'b1;
        busAddr <= 8'ha5;
        cyc(2);
        chk(pinOeN, 8'h00);
        chk(pinOut, 8'ha5);
        addrOutEn <= 1'b0;
        wrDataOutEn <= 1'b1;
        busWrData <= 8'h69;
        cyc(2);
        chk(pinOut, 8'h69);
        wrDataOutEn <= 1'b0;
        internalReadCycle <= 1'b1;
        internalRdData <= 8'h7e;
        cyc(2);
        chk(pinOeN, 8'hff);
        internalReadCycle <= 1'b0;
        busTristateCtl <= 1'b1;
        devDrive <= 1'b1;
        devData <= 8'hc3;
        rdDataInEn <= 1'b1;
        cyc(8);
        chk(cpuRdData, 8'hc3);
        lowpowerN <= 1'b0;
        devData <= 8'h0f;
        cyc(8);
        chk(cpuRdData, 8'hc3);
        lowpowerN <= 1'b1;
        expandedModeSel <= 1'b0;
        wr(4'h2, 8'h00);
        wr(4'h3, 8'h0e);
        devData <= 8'h96;
        cyc(2);
        chk(pinOeN, 8'hff);
        strobeAIn <= 1'b1;
        cyc(2);
        chk(pinOeN, 8'h00);
        for (int i = 0; i < 20 && strobeAFlag !== 1'b1; i++) cyc(1);
        chk({7'h00, strobeAFlag}, 8'h01);
        if (strobeAFlag !== 1'b1) conclude;
        rd(4'h1, 8'h96);
        rd(4'h0, 8'h3c);
        rd(4'h4, 8'h01);
        wr(4'h5, 8'h01);
        chk({7'h00, irq}, 8'h01);
        wr(4'h6, 8'h01);
        chk({7'h00, irq}, 8'h00);
        wr(4'h3, 8'h10);
        expandedModeSel <= 1'b1;
        busTristateCtl <= 1'b0;
        internalReadCycle <= 1'b1;
        cyc(2);
        chk(pinOut, 8'h7e);
        chk(pinOeN, 8'h00);
        rd(4'hf, 8'h00);
        conclude;
    end
endmodule

// *** mux_bus_port_chk.sv ***
/* Checker: bus drive, read capture, register port idle, flag and irq.
   Assumes binding onto the port top, one clock domain. */
`timescale 1ns/1ns
module mux_bus_port_chk #(parameter WIDTH = 8) (
    input wire clock, srst, expandedModeSel, ePhase, phaseTwoFall, busTristateCtl,
    input wire addrOutEn, wrDataOutEn, rdDataInEn, internalReadCycle, lowpowerN, regRd,
    input wire [WIDTH-1:0] busAddr, busWrData, pinIn, pinOut, pinOeN, cpuRdData, regRdData,
    input wire strobeAFlag, irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // Two steps: capture while E high, then hand over after E falls
    sequence capWin;
        expandedModeSel && ePhase && lowpowerN ##1 !ePhase && rdDataInEn;
    endsequence
    a_reset_float: assert property (disable iff (1'b0) srst |=> &pinOeN)
        else $error("pins driven after reset");
    a_tristate_float: assert property (expandedModeSel && busTristateCtl |=> &pinOeN)
        else $error("bus not released");
    a_addr_out: assert property (expandedModeSel && !busTristateCtl && addrOutEn
        |=> !(|pinOeN) && pinOut == $past(busAddr)) else $error("address not driven");
    a_wdata_out: assert property (expandedModeSel && !busTristateCtl && !addrOutEn
        && wrDataOutEn && !internalReadCycle |=> pinOut == $past(busWrData))
        else $error("write data not driven");
    a_read_capture: assert property (capWin |=> cpuRdData == $past(pinIn, 2))
        else $error("read data not captured");
    a_rd_idle: assert property (!regRd |=> !(|regRdData)) else $error("stray read data");
    a_irq_cause: assert property (irq |-> $past(strobeAFlag)) else $error("irq without flag");
    a_flag_sync: assert property ($rose(strobeAFlag) |-> $past(phaseTwoFall))
        else $error("flag set off phase");
endmodule
bind mux_bus_handshake_port mux_bus_port_chk #(.WIDTH(WIDTH)) i_mux_bus_port_chk (.clock,
    .srst, .expandedModeSel, .ePhase, .phaseTwoFall, .busTristateCtl, .addrOutEn,
    .wrDataOutEn, .rdDataInEn, .internalReadCycle, .lowpowerN, .regRd, .busAddr, .busWrData,
    .pinIn, .pinOut, .pinOeN, .cpuRdData, .regRdData, .strobeAFlag, .irq);

// *** mux_bus_port_defs.vh ***
/*
  Shared constants for the multiplexed bus / handshake port.
  Assumes inclusion by bare name from the design file.
*/
`ifndef MUX_BUS_PORT_DEFS_VH
`define MUX_BUS_PORT_DEFS_VH
`define ADDR_PORT_DATA 4'h0
`define ADDR_LATCHED_DATA 4'h1
`define ADDR_DIR 4'h2
`define ADDR_CTRL 4'h3
`define ADDR_IRQ_STATUS 4'h4
`define ADDR_IRQ_ENABLE 4'h5
`define ADDR_IRQ_CLEAR 4'h6
`define CTRL_OPEN_DRAIN 0
`define CTRL_HANDSHAKE 1
`define CTRL_OUT_DIR 2
`define CTRL_EDGE_SEL 3
`define CTRL_IRV 4
`define RST_DIR 8'h00
`define RST_CTRL 5'h00
`endif

// *** port_pin_partner.sv ***
/* Far-side device on the port pins.
   Assumes active-low enables from the port and pull-ups on every line. */
`timescale 1ns/1ns
module port_pin_partner (
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOeN,
    input wire logic [7:0] devData,
    input wire logic devDrive,
    output logic [7:0] pinIn
);
    // Released lines read devData when the device drives, else high via pull-ups, never a stale value
    assign pinIn = (~pinOeN & pinOut) | (pinOeN & (devDrive ? devData : 8'hff));
endmodule
